// File: core/cpwm_pkg.sv
// constants, field layouts and carrier types of the cascaded 16-bit modulation / pulse timer
// ============================================================================
// Overview of operation
// - both 8-bit halves cascade into one 16-bit up-counter on the selected source tick
// - modulation mode: counter equals duty, output flop inverts, counter keeps counting
// - modulation mode: overflow inverts flop again, clears counter, raises period-end pulse
// - reset clears the output flop; otherwise initial-level bit sets its start level
// - modulation pin shows the inverse of the output flop
// - pulse pin shows the inverse of the output flop
// - modulation mode: duty written while running loads on the period-end event
// - modulation mode: duty written while stopped loads right after the write
// - modulation mode: duty read while running returns the active, older value
// - stopped counter holds the pin level until the next upper control write reloads it from the initial-level bit
// - upper control bit 3 runs; clearing bit 7 after stop drives the pin high
// - lower control 33H selects main clock divided by 8 and cascade operation
// - upper control 056H selects modulation with level 0; 05EH also starts
// - upper control 057H selects pulse generation with level 0; 05FH also starts
// - pulse mode: duty match inverts; period match inverts, clears, raises period end
// - pulse mode: duty and period are unbuffered, writes act at once
package cpwm_pkg;

	// ============================================================================
	// register map, one aligned word each
	localparam logic [7:0] OFF_LOWER_CTRL = 8'h00;
	localparam logic [7:0] OFF_UPPER_CTRL = 8'h04;
	localparam logic [7:0] OFF_DUTY_LOW = 8'h08;
	localparam logic [7:0] OFF_DUTY_HIGH = 8'h0C;
	localparam logic [7:0] OFF_PERIOD_LOW = 8'h10;
	localparam logic [7:0] OFF_PERIOD_HIGH = 8'h14;
	localparam logic [7:0] OFF_PRESCALE_CFG = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;

	localparam logic [7:0] LOWER_CTRL_RESET = 8'h00;
	localparam logic [7:0] UPPER_CTRL_RESET = 8'h00;
	localparam logic [15:0] DUTY_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'h0000;

	// ============================================================================
	// field codes
	localparam logic [2:0] OPM_CASCADE = 3'h3;
	localparam logic [2:0] MODE_PWM16 = 3'h6;
	localparam logic [2:0] MODE_PPG16 = 3'h7;
	localparam int unsigned STAT_RUN_BIT = 17;
	localparam int unsigned STAT_FLOP_BIT = 16;

	// source select codes of the lower control register
	localparam logic [2:0] SRC_TAP = 3'h0;
	localparam logic [2:0] SRC_DIV7 = 3'h1;
	localparam logic [2:0] SRC_DIV5 = 3'h2;
	localparam logic [2:0] SRC_DIV3 = 3'h3;
	localparam logic [2:0] SRC_SLOW = 3'h4;
	localparam logic [2:0] SRC_DIV1 = 3'h5;
	localparam logic [2:0] SRC_FAST = 3'h6;
	localparam logic [2:0] SRC_EXT = 3'h7;

	// divider exponents of the main clock and of the slow clock
	localparam int unsigned EXP_TAP_FAST = 11;
	localparam int unsigned EXP_TAP_SLOW = 3;
	localparam int unsigned EXP_DIV7 = 7;
	localparam int unsigned EXP_DIV5 = 5;
	localparam int unsigned EXP_DIV3 = 3;
	localparam int unsigned EXP_DIV1 = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ============================================================================
	// carriers
	typedef struct packed {
		logic spare7;
		logic [2:0] source_sel;
		logic spare3;
		logic [2:0] op_mode;
	} cpwm_lower_ctrl_t;

	typedef struct packed {
		logic initial_level;
		logic [2:0] aux;
		logic run;
		logic [2:0] mode;
	} cpwm_upper_ctrl_t;

	typedef enum logic [1:0] {
		CPWM_WS_IDLE = 2'b00,
		CPWM_WS_RESP = 2'b01
	} cpwm_wr_state_t;

endpackage

// File: core/cpwm_prescaler.sv
// source tick generator: main clock divider, slow clock and external count input
`timescale 1ns/1ps
module cpwm_prescaler (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] source_sel,
	input wire logic prescaler_tap_select,
	input wire logic slow_clk_pin,
	input wire logic external_count_input,
	output logic tick
);

	logic [10:0] div_q;
	logic [2:0] slow_sync_q;
	logic [2:0] ext_sync_q;
	logic [2:0] slow_div_q;
	logic slow_rise;
	logic ext_rise;
	logic tick_d;

	function automatic logic low_ones(input logic [10:0] v, input int unsigned e);
		logic [10:0] m;
		m = 11'((32'd1 << e) - 32'd1);
		return (v & m) == m;
	endfunction

	// stage 0 is only read by stage 1; edges are taken from stages 1 and 2
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_sync_q <= 3'h0;
			ext_sync_q <= 3'h0;
		end else begin
			slow_sync_q <= {slow_sync_q[1:0], slow_clk_pin};
			ext_sync_q <= {ext_sync_q[1:0], external_count_input};
		end
	end

	assign slow_rise = slow_sync_q[1] & ~slow_sync_q[2];
	assign ext_rise = ext_sync_q[1] & ~ext_sync_q[2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 11'h000;
			slow_div_q <= 3'h0;
		end else begin
			div_q <= div_q + 11'h001;
			if (slow_rise) begin
				slow_div_q <= slow_div_q + 3'h1;
			end
		end
	end

	always_comb begin
		case (source_sel)
			cpwm_pkg::SRC_TAP: tick_d = prescaler_tap_select ?
				(slow_rise && low_ones({8'h00, slow_div_q}, cpwm_pkg::EXP_TAP_SLOW)) :
				low_ones(div_q, cpwm_pkg::EXP_TAP_FAST);
			cpwm_pkg::SRC_DIV7: tick_d = low_ones(div_q, cpwm_pkg::EXP_DIV7);
			cpwm_pkg::SRC_DIV5: tick_d = low_ones(div_q, cpwm_pkg::EXP_DIV5);
			cpwm_pkg::SRC_DIV3: tick_d = low_ones(div_q, cpwm_pkg::EXP_DIV3);
			cpwm_pkg::SRC_SLOW: tick_d = slow_rise;
			cpwm_pkg::SRC_DIV1: tick_d = low_ones(div_q, cpwm_pkg::EXP_DIV1);
			cpwm_pkg::SRC_FAST: tick_d = 1'b1;
			cpwm_pkg::SRC_EXT: tick_d = ext_rise;
			default: tick_d = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick <= 1'b0;
		end else begin
			tick <= tick_d;
		end
	end

endmodule

// File: core/cpwm_timer.sv
// cascaded 16-bit modulation / pulse generator with an AXI4-Lite register slave
`timescale 1ns/1ps
module cpwm_timer #(
	parameter int unsigned CNT_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic slow_clk_pin,
	input wire logic external_count_input,
	output logic modulation_out_n,
	output logic pulse_gen_out_n,
	output logic period_end_irq
);

	// ============================================================================
	// elaboration check
	generate
		if (CNT_W != 16) begin : g_bad_width
			$error("cpwm_timer: counter width must be 16");
		end
	endgenerate

	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	// ============================================================================
	// declarations
	cpwm_pkg::cpwm_wr_state_t ws_q;
	cpwm_pkg::cpwm_lower_ctrl_t lower_counter_control;
	cpwm_pkg::cpwm_upper_ctrl_t upper_counter_control;
	logic prescaler_tap_select;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_got_q, w_got_q;
	logic aw_take, w_take, have_aw, have_w, wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_word;
	logic [15:0] duty_hold_q, duty_active_q, period_q;
	logic [CNT_W-1:0] cnt_q, cnt_nx;
	logic output_toggle_flop;
	logic tick, cascaded, pwm_mode, ppg_mode, running;
	logic duty_hit, end_evt, upper_wr;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= cpwm_pkg::OFF_STATUS;
	endfunction

	// ============================================================================
	// write channel: address and data taken in either order
	assign aw_take = awvalid && awready;
	assign w_take = wvalid && wready;
	assign have_aw = aw_got_q || aw_take;
	assign have_w = w_got_q || w_take;
	assign wr_en = (ws_q == cpwm_pkg::CPWM_WS_IDLE) && have_aw && have_w;
	assign wr_addr = aw_got_q ? aw_addr_q : awaddr;
	assign wr_data = w_got_q ? w_data_q : wdata;
	assign wr_strb = w_got_q ? w_strb_q : wstrb;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ws_q <= cpwm_pkg::CPWM_WS_IDLE;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= cpwm_pkg::RESP_OKAY;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			case (ws_q)
				cpwm_pkg::CPWM_WS_IDLE: begin
					if (aw_take) begin
						aw_got_q <= 1'b1;
						aw_addr_q <= awaddr;
					end
					if (w_take) begin
						w_got_q <= 1'b1;
						w_data_q <= wdata;
						w_strb_q <= wstrb;
					end
					awready <= !have_aw;
					wready <= !have_w;
					if (wr_en) begin
						ws_q <= cpwm_pkg::CPWM_WS_RESP;
						bvalid <= 1'b1;
						bresp <= mapped(wr_addr) ? cpwm_pkg::RESP_OKAY : cpwm_pkg::RESP_SLVERR;
						aw_got_q <= 1'b0;
						w_got_q <= 1'b0;
						awready <= 1'b0;
						wready <= 1'b0;
					end
				end
				cpwm_pkg::CPWM_WS_RESP: begin
					if (bready) begin
						ws_q <= cpwm_pkg::CPWM_WS_IDLE;
						bvalid <= 1'b0;
						awready <= 1'b1;
						wready <= 1'b1;
					end
				end
				default: ws_q <= cpwm_pkg::CPWM_WS_IDLE;
			endcase
		end
	end

	// ============================================================================
	// read channel, answer one cycle after the address is taken
	always_comb begin
		rd_word = 32'h0000_0000;
		case (araddr[7:2])
			cpwm_pkg::OFF_LOWER_CTRL[7:2]: rd_word[7:0] = lower_counter_control;
			cpwm_pkg::OFF_UPPER_CTRL[7:2]: rd_word[7:0] = upper_counter_control;
			// while modulating, reads show the active value, not the pending one
			cpwm_pkg::OFF_DUTY_LOW[7:2]: rd_word[7:0] = (running && pwm_mode) ?
				duty_active_q[7:0] : duty_hold_q[7:0];
			cpwm_pkg::OFF_DUTY_HIGH[7:2]: rd_word[7:0] = (running && pwm_mode) ?
				duty_active_q[15:8] : duty_hold_q[15:8];
			cpwm_pkg::OFF_PERIOD_LOW[7:2]: rd_word[7:0] = period_q[7:0];
			cpwm_pkg::OFF_PERIOD_HIGH[7:2]: rd_word[7:0] = period_q[15:8];
			cpwm_pkg::OFF_PRESCALE_CFG[7:2]: rd_word[0] = prescaler_tap_select;
			cpwm_pkg::OFF_STATUS[7:2]: begin
				rd_word[15:0] = cnt_q;
				rd_word[cpwm_pkg::STAT_FLOP_BIT] = output_toggle_flop;
				rd_word[cpwm_pkg::STAT_RUN_BIT] = running;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= cpwm_pkg::RESP_OKAY;
		end else if (rvalid) begin
			if (rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			arready <= 1'b0;
			rdata <= mapped(araddr) ? rd_word : 32'h0000_0000;
			rresp <= mapped(araddr) ? cpwm_pkg::RESP_OKAY : cpwm_pkg::RESP_SLVERR;
		end else begin
			arready <= 1'b1;
		end
	end

	// ============================================================================
	// control and timer registers, byte lane 0 only
	// unaligned or unmapped addresses answer SLVERR and must not store anything
	assign upper_wr = wr_en && wr_strb[0] && mapped(wr_addr)
		&& hit(wr_addr, cpwm_pkg::OFF_UPPER_CTRL);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lower_counter_control <= cpwm_pkg::LOWER_CTRL_RESET;
			upper_counter_control <= cpwm_pkg::UPPER_CTRL_RESET;
			prescaler_tap_select <= 1'b0;
			duty_hold_q <= cpwm_pkg::DUTY_RESET;
			period_q <= cpwm_pkg::PERIOD_RESET;
		end else if (wr_en && wr_strb[0] && mapped(wr_addr)) begin
			if (hit(wr_addr, cpwm_pkg::OFF_LOWER_CTRL))
				lower_counter_control <= wr_data[7:0];
			if (upper_wr)
				upper_counter_control <= wr_data[7:0];
			if (hit(wr_addr, cpwm_pkg::OFF_PRESCALE_CFG))
				prescaler_tap_select <= wr_data[0];
			if (hit(wr_addr, cpwm_pkg::OFF_DUTY_LOW))
				duty_hold_q[7:0] <= wr_data[7:0];
			if (hit(wr_addr, cpwm_pkg::OFF_DUTY_HIGH))
				duty_hold_q[15:8] <= wr_data[7:0];
			if (hit(wr_addr, cpwm_pkg::OFF_PERIOD_LOW))
				period_q[7:0] <= wr_data[7:0];
			if (hit(wr_addr, cpwm_pkg::OFF_PERIOD_HIGH))
				period_q[15:8] <= wr_data[7:0];
		end
	end

	// ============================================================================
	// counter core
	assign cascaded = lower_counter_control.op_mode == cpwm_pkg::OPM_CASCADE;
	assign pwm_mode = cascaded && upper_counter_control.mode == cpwm_pkg::MODE_PWM16;
	assign ppg_mode = cascaded && upper_counter_control.mode == cpwm_pkg::MODE_PPG16;
	assign running = upper_counter_control.run && (pwm_mode || ppg_mode);
	assign cnt_nx = cnt_q + CNT_MAX + {{(CNT_W-1){1'b0}}, 1'b1} - CNT_MAX;
	// pulse mode compares the unbuffered register, so a write acts at once
	assign duty_hit = cnt_nx == (ppg_mode ? duty_hold_q : duty_active_q);
	assign end_evt = ppg_mode ? (cnt_nx == period_q) : (cnt_q == CNT_MAX);

	cpwm_prescaler u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.source_sel(lower_counter_control.source_sel),
		.prescaler_tap_select(prescaler_tap_select),
		.slow_clk_pin(slow_clk_pin),
		.external_count_input(external_count_input),
		.tick(tick)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			output_toggle_flop <= 1'b0;
			period_end_irq <= 1'b0;
		end else begin
			period_end_irq <= 1'b0;
			if (!running) begin
				cnt_q <= '0;
				// level holds through a stop; the stopping write lands in the running
				// branch, so only a later control write reloads the flop from the level bit
				if (upper_wr)
					output_toggle_flop <= wr_data[7];
			end else if (tick) begin
				if (end_evt) begin
					cnt_q <= '0;
					period_end_irq <= 1'b1;
					output_toggle_flop <= output_toggle_flop ^ ~duty_hit;
				end else begin
					cnt_q <= cnt_nx;
					output_toggle_flop <= output_toggle_flop ^ duty_hit;
				end
			end
		end
	end

	// stopped: copy follows the write one cycle later; running modulation: load at period end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			duty_active_q <= cpwm_pkg::DUTY_RESET;
		end else if (!running) begin
			duty_active_q <= duty_hold_q;
		end else if (pwm_mode && tick && end_evt) begin
			duty_active_q <= duty_hold_q;
		end
	end

	// pins are inverted flop levels, idle high outside their own mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			modulation_out_n <= 1'b1;
			pulse_gen_out_n <= 1'b1;
		end else begin
			modulation_out_n <= pwm_mode ? ~output_toggle_flop : 1'b1;
			pulse_gen_out_n <= ppg_mode ? ~output_toggle_flop : 1'b1;
		end
	end

	// ============================================================================
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_pwm_wrap;
		running && pwm_mode && tick && cnt_q == CNT_MAX;
	endsequence

	sequence s_ppg_end;
		running && ppg_mode && tick && cnt_nx == period_q && cnt_nx != duty_hold_q;
	endsequence

	a_pwm_overflow_end: assert property (s_pwm_wrap |=> period_end_irq && cnt_q == '0)
		else $error("overflow did not clear counter and pulse period end");
	a_ppg_period_end: assert property (s_ppg_end |=>
		period_end_irq && cnt_q == '0 && output_toggle_flop != $past(output_toggle_flop))
		else $error("period match did not end the pulse period");
	a_duty_match_flip: assert property (running && pwm_mode && tick && cnt_q != CNT_MAX
		&& cnt_nx == duty_active_q |=> output_toggle_flop != $past(output_toggle_flop)
		&& cnt_q != '0)
		else $error("duty match did not invert the flop or cleared the counter");
	a_count_advance: assert property (running && tick && !end_evt |=>
		cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not advance on a tick");
	a_reset_flop_low: assert property ($rose(aresetn) |-> output_toggle_flop == 1'b0)
		else $error("flop not cleared by reset");
	a_pwm_pin_level: assert property (pwm_mode |=>
		modulation_out_n == !$past(output_toggle_flop))
		else $error("modulation pin is not the inverted flop");
	a_ppg_pin_level: assert property (ppg_mode |=>
		pulse_gen_out_n == !$past(output_toggle_flop))
		else $error("pulse pin is not the inverted flop");
	a_duty_held_run: assert property (running && pwm_mode && !(tick && end_evt) |=>
		duty_active_q == $past(duty_active_q))
		else $error("active duty changed before period end");
	a_duty_load_stop: assert property (!running ##1 !running |->
		duty_active_q == $past(duty_hold_q))
		else $error("stopped duty write did not load at once");
	a_stop_holds_pin: assert property (!running && !upper_wr |=>
		$stable(output_toggle_flop))
		else $error("flop changed while stopped without a level write");
	a_level_clear_high: assert property (!running && upper_wr && !wr_data[7] ##1 pwm_mode
		|=> modulation_out_n)
		else $error("clearing the level bit did not drive the pin high");

endmodule

// File: verification/cascaded_16bit_pwm_ppg_tb.sv
// self-checking bench of the cascaded 16-bit modulation / pulse timer
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module cascaded_16bit_pwm_ppg_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic slow_clk_pin, external_count_input;
	logic awready, wready, bvalid, arready, rvalid;
	logic modulation_out_n, pulse_gen_out_n, period_end_irq;
	logic [1:0] bresp, rresp;
	logic [1:0] exp_b[$];
	logic [34:0] exp_r[$];
	logic [34:0] e_r;
	int failures = 0;
	int n_compared = 0;
	int ppg_low = 0;
	int pwm_low = 0;
	int n, l0, i;
	integer seed = 66;
	logic [31:0] rnd;

	cpwm_timer #(.CNT_W(16)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .slow_clk_pin(slow_clk_pin), .external_count_input(external_count_input),
		.modulation_out_n(modulation_out_n), .pulse_gen_out_n(pulse_gen_out_n),
		.period_end_irq(period_end_irq));

	// ============================================================================
	// clock, pin low-time counters and response monitor
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// non-blocking so that reads right after an edge always see the pre-edge count
	// the shared port latch lies outside this block; pins are watched as if it were set
	always @(posedge aclk) begin
		if (pulse_gen_out_n === 1'b0) ppg_low <= ppg_low + 1;
		if (modulation_out_n === 1'b0) pwm_low <= pwm_low + 1;
	end

	always @(posedge aclk) begin
		if (bvalid === 1'b1 && bready === 1'b1) begin
			if (exp_b.size() > 0) `CHK(bresp, exp_b.pop_front())
		end
		if (rvalid === 1'b1 && rready === 1'b1 && exp_r.size() > 0) begin
			e_r = exp_r.pop_front();
			if (e_r[34]) `CHK({rresp, rdata}, e_r[33:0])
		end
	end

	// ============================================================================
	// closing and bus tasks
	task automatic print_verdict;
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic time_out;
		failures++;
		$display("ERROR t=%0t wait limit used up", $time);
		print_verdict();
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int k;
		exp_b.push_back(er);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		if (k == 100) time_out();
		@(posedge aclk);
	endtask

	task automatic axi_read(input logic [7:0] a, input bit care, input logic [1:0] er,
		input logic [31:0] ev, output logic [31:0] v);
		int k;
		exp_r.push_back({care, er, ev});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		v = rdata;
		rready <= 1'b0;
		if (k == 100) time_out();
		@(posedge aclk);
	endtask

	// 16-bit values go low byte first, never one byte alone
	task automatic set16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
		axi_write(lo, v[7:0], 4'hF, cpwm_pkg::RESP_OKAY);
		axi_write(hi, v[15:8], 4'hF, cpwm_pkg::RESP_OKAY);
	endtask

	// counts edges until the period-end pulse is sampled high
	task automatic wait_irq(input int lim, output int c);
		for (c = 1; c <= lim; c++) begin
			@(posedge aclk);
			if (period_end_irq === 1'b1) break;
		end
		if (c > lim) time_out();
	endtask

	// ============================================================================
	// main sequence
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		wstrb = 4'h0;
		slow_clk_pin = 1'b0;
		external_count_input = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);

		`CHK(modulation_out_n, 1'b1)
		`CHK(pulse_gen_out_n, 1'b1)
		// an unaligned write must not reach the register it half addresses
		axi_write(8'h11, 8'hFF, 4'hF, cpwm_pkg::RESP_SLVERR);
		for (i = 0; i < 8; i++) axi_read(8'(i * 4), 1, cpwm_pkg::RESP_OKAY, 32'h0, rd);
		axi_read(8'h20, 1, cpwm_pkg::RESP_SLVERR, 32'h0, rd);
		rnd = $random(seed);
		axi_write(cpwm_pkg::OFF_PERIOD_LOW, rnd[7:0], 4'hF, cpwm_pkg::RESP_OKAY);
		axi_write(cpwm_pkg::OFF_PERIOD_LOW, ~rnd[7:0], 4'h0, cpwm_pkg::RESP_OKAY);
		axi_read(cpwm_pkg::OFF_PERIOD_LOW, 1, cpwm_pkg::RESP_OKAY, {24'h0, rnd[7:0]}, rd);
		$display("test reset and register map done");

		// pulse generation on every clock, then at main clock / 8 and / 2: duty 0x0080, period 0x0102
		axi_write(cpwm_pkg::OFF_LOWER_CTRL, 8'h63, 4'hF, cpwm_pkg::RESP_OKAY);
		set16(cpwm_pkg::OFF_DUTY_LOW, cpwm_pkg::OFF_DUTY_HIGH, 16'h0080);
		set16(cpwm_pkg::OFF_PERIOD_LOW, cpwm_pkg::OFF_PERIOD_HIGH, 16'h0102);
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h57, 4'hF, cpwm_pkg::RESP_OKAY);
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h5F, 4'hF, cpwm_pkg::RESP_OKAY);
		wait_irq(1000, n);
		l0 = ppg_low;
		wait_irq(1000, n);
		`CHK(n, 258)
		`CHK(ppg_low - l0, 130)
		`CHK(modulation_out_n, 1'b1)
		@(posedge aclk);
		`CHK(period_end_irq, 1'b0)
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h57, 4'hF, cpwm_pkg::RESP_OKAY);
		axi_write(cpwm_pkg::OFF_LOWER_CTRL, 8'h33, 4'hF, cpwm_pkg::RESP_OKAY);
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h5F, 4'hF, cpwm_pkg::RESP_OKAY);
		wait_irq(5000, n);
		wait_irq(5000, n);
		`CHK(n, 2064)
		// stop past the duty match, so the level held is the low one
		repeat (1400) @(posedge aclk);
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h57, 4'hF, cpwm_pkg::RESP_OKAY);
		axi_read(cpwm_pkg::OFF_STATUS, 0, cpwm_pkg::RESP_OKAY, 32'h0, rd);
		repeat (20) @(posedge aclk);
		`CHK(pulse_gen_out_n, 1'b0)
		`CHK(rd[cpwm_pkg::STAT_FLOP_BIT], 1'b1)
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h57, 4'hF, cpwm_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(pulse_gen_out_n, 1'b1)
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'hD7, 4'hF, cpwm_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(pulse_gen_out_n, 1'b0)
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h57, 4'hF, cpwm_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(pulse_gen_out_n, 1'b1)
		axi_write(cpwm_pkg::OFF_LOWER_CTRL, 8'h53, 4'hF, cpwm_pkg::RESP_OKAY);
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h5F, 4'hF, cpwm_pkg::RESP_OKAY);
		wait_irq(1000, n);
		wait_irq(1000, n);
		`CHK(n, 516)
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h57, 4'hF, cpwm_pkg::RESP_OKAY);
		$display("test pulse generation done");

		// modulation on every clock: duty 0x8000 loaded while stopped, 0x1000 while running
		axi_write(cpwm_pkg::OFF_LOWER_CTRL, 8'h63, 4'hF, cpwm_pkg::RESP_OKAY);
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h56, 4'hF, cpwm_pkg::RESP_OKAY);
		set16(cpwm_pkg::OFF_DUTY_LOW, cpwm_pkg::OFF_DUTY_HIGH, 16'h8000);
		l0 = pwm_low;
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h5E, 4'hF, cpwm_pkg::RESP_OKAY);
		set16(cpwm_pkg::OFF_DUTY_LOW, cpwm_pkg::OFF_DUTY_HIGH, 16'h1000);
		axi_read(cpwm_pkg::OFF_DUTY_HIGH, 1, cpwm_pkg::RESP_OKAY, 32'h80, rd);
		wait_irq(70000, n);
		repeat (3) @(posedge aclk);
		`CHK(pwm_low - l0, 32768)
		`CHK(modulation_out_n, 1'b1)
		`CHK(pulse_gen_out_n, 1'b1)
		axi_read(cpwm_pkg::OFF_DUTY_HIGH, 1, cpwm_pkg::RESP_OKAY, 32'h10, rd);
		axi_write(cpwm_pkg::OFF_UPPER_CTRL, 8'h56, 4'hF, cpwm_pkg::RESP_OKAY);
		$display("test modulation done");
		print_verdict();
	end
endmodule
